// ---- verification/csr_core_regs_tb.sv ----
// Purpose: Self-checking bench for the core special register bank
// Assumes: Core side driven at falling edges, one access per task call
// Notes:   Port pins, timer count and current PC are held constant
`timescale 1ns/10ps
module csr_core_regs_tb;
    import csr_pkg::*;
    logic        clk, reset_n, clkEn, wdtSleepReset, memWrite, memRead;
    logic        aluUpdate, aluIsArith, aluCarry, aluHalfCarry, aluCarryIn7;
    logic        rotateCarry, rotateCarryVal, haltInstr, watchdogClearInstr;
    logic        watchdogTimeout, irqEntry, returnFromIrq, tableRead;
    logic        memPhysSel, pcJump, dummyCycle, tableLowValid;
    logic        globalIrqGate, timer0Load, voiceRomReq;
    logic [2:0]  watchdogDivSel;
    logic [7:0]  memAddr, memWdata, memRdata, ramRdata, aluResult;
    logic [7:0]  tableLowByte, statusFlags, irqControlLow, irqControlHigh;
    logic [7:0]  timer0Live, timer0Preload, portADirection, portAOut;
    logic [7:0]  portAPins, voiceRomData, voiceRomByte, rdv, st, vl;
    logic [8:0]  memPhysAddr;
    logic [12:0] pcCurrent, pcJumpAddr, romAddr;
    logic [15:0] romData;
    logic [21:0] voiceRomAddr;
    int          errTotal, compares, cyc, w;

    csr_core_regs csr_core_regs_i (
        .clk, .reset_n, .clkEn, .wdtSleepReset, .memAddr, .memWrite,
        .memRead, .memWdata, .memRdata, .memPhysAddr, .memPhysSel,
        .ramRdata, .aluUpdate, .aluIsArith, .aluResult, .aluCarry,
        .aluHalfCarry, .aluCarryIn7, .rotateCarry, .rotateCarryVal,
        .haltInstr, .watchdogClearInstr, .watchdogTimeout, .irqEntry,
        .returnFromIrq, .tableRead, .pcCurrent, .pcJumpAddr, .pcJump,
        .dummyCycle, .romAddr, .romData, .tableLowByte, .tableLowValid,
        .watchdogDivSel, .statusFlags, .globalIrqGate, .irqControlLow,
        .irqControlHigh, .timer0Live, .timer0Preload, .timer0Load,
        .portADirection, .portAOut, .portAPins, .voiceRomAddr,
        .voiceRomReq, .voiceRomData, .voiceRomByte
    );

    csr_far_model csr_far_model_i (
        .clk, .romAddr, .romData, .voiceRomAddr, .voiceRomData,
        .memPhysAddr, .ramRdata
    );

    // Free running clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errTotal++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Compares %0d, mismatches %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    // Register write: strobe held over exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        memAddr  = a;
        memWdata = d;
        memWrite = 1'b1;
        @(negedge clk);
        memWrite = 1'b0;
    endtask : wr

    // Register read: data is settled by the following falling edge
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        memAddr = a;
        memRead = 1'b1;
        @(negedge clk);
        memRead = 1'b0;
        rdv     = memRdata;
    endtask : rd

    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse

    task automatic do_reset(input logic sleepRst);
        @(negedge clk);
        wdtSleepReset = sleepRst;
        reset_n       = 1'b0;
        repeat (6) @(negedge clk);
        reset_n       = 1'b1;
        wdtSleepReset = 1'b0;
    endtask : do_reset

    // One flag update from the ALU with its expected status nibble
    task automatic alu(input logic [7:0] r, input logic [3:0] f,
                       input logic [3:0] exp);
        aluResult    = r;
        {aluIsArith, aluCarry, aluHalfCarry, aluCarryIn7} = f;
        pulse(aluUpdate);
        chk(statusFlags[3:0], exp);
    endtask : alu

    // Hang guard: the full run needs under two thousand cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            errTotal++;
            report_and_stop();
        end
    end

    initial begin
        {memWrite, memRead, aluUpdate, aluIsArith, aluCarry} = '0;
        {aluHalfCarry, aluCarryIn7, rotateCarry, rotateCarryVal} = '0;
        {haltInstr, watchdogClearInstr, watchdogTimeout, irqEntry} = '0;
        {returnFromIrq, tableRead, wdtSleepReset, memAddr} = '0;
        {memWdata, aluResult, timer0Live} = '0;
        {errTotal, compares, cyc} = '0;
        clkEn     = 1'b1;
        reset_n   = 1'b0;
        pcCurrent = 13'h1A00;
        portAPins = 8'hA5;
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        // Reset values, then an unmapped place reads as zero
        chk(watchdogDivSel, WDSEL_RESET);
        chk({portADirection, portAOut}, {PORT_RESET, PORT_RESET});
        chk({statusFlags, irqControlLow}, 16'h0000);
        rd(ADDR_BANK);
        chk(rdv, 8'h00);
        wr(ADDR_WDSEL, 8'hFD);
        chk(watchdogDivSel, 3'h5);
        rd(8'h3F);
        chk(rdv, BYTE_ZERO);
        // Bank routing for both windows, direct access and special area
        wr(ADDR_PTR0, 8'h50);
        wr(ADDR_PTR1, 8'h60);
        wr(ADDR_TPTR, 8'h34);
        for (int b = 1; b >= 0; b--) begin
            wr(ADDR_BANK, 8'(b));
            rd(ADDR_IND0);
            chk({memPhysSel, memPhysAddr}, {2'b10, 8'h50});
            rd(ADDR_IND1);
            chk({memPhysSel, memPhysAddr}, {1'b1, 1'(b), 8'h60});
            rd(8'h70);
            chk({memPhysSel, memPhysAddr}, {2'b10, 8'h70});
            rd(ADDR_TPTR);
            chk({memPhysSel, rdv}, {1'b0, 8'h34});
        end
        // Sleep watchdog reset keeps bank and status, a plain one clears
        wr(ADDR_BANK, 8'h01);
        pulse(haltInstr);
        do_reset(1'b1);
        rd(ADDR_BANK);
        chk({rdv, statusFlags[4]}, {8'h01, 1'b1});
        do_reset(1'b0);
        rd(ADDR_BANK);
        chk({rdv, statusFlags}, {8'h00, 8'h00});
        // A frozen clock enable must swallow the write
        clkEn = 1'b0;
        wr(ADDR_WDSEL, 8'h02);
        clkEn = 1'b1;
        chk(watchdogDivSel, WDSEL_RESET);
        // Low counter write: jump in page, then one dummy cycle
        wr(ADDR_PCL, 8'h9C);
        chk({pcJump, pcJumpAddr}, {1'b1, pcCurrent[12:8], 8'h9C});
        @(negedge clk);
        chk({pcJump, dummyCycle}, 2'b01);
        wr(ADDR_TIMER0_COUNT, 8'h9A);
        chk({timer0Load, timer0Preload}, {1'b1, 8'h9A});
        // Table read of the word at the pointer
        wr(ADDR_TPTR, 8'h34);
        chk(romAddr, {pcCurrent[12:8], 8'h34});
        pulse(tableRead);
        chk({tableLowValid, tableLowByte}, {1'b1, 8'h34});
        rd(ADDR_THIGH);
        chk(rdv, 8'hCB);
        // Status writes, halt, expiry and clear
        wr(ADDR_STATUS, 8'hFF);
        chk(statusFlags, 8'h0F);
        pulse(haltInstr);
        chk(statusFlags[5:4], 2'b01);
        pulse(watchdogTimeout);
        wr(ADDR_STATUS, 8'h00);
        chk(statusFlags, 8'h30);
        pulse(watchdogClearInstr);
        chk(statusFlags[5:4], 2'b00);
        pulse(watchdogTimeout);
        pulse(haltInstr);
        chk(statusFlags[5:4], 2'b01);
        alu(8'h00, 4'b1100, 4'hD);
        alu(8'h80, 4'b1011, 4'hA);
        alu(8'h01, 4'b1111, 4'h3);
        alu(8'h00, 4'b0000, 4'h7);
        pulse(rotateCarry);
        chk(statusFlags[3:0], 4'h6);
        rotateCarryVal = 1'b1;
        pulse(rotateCarry);
        chk(statusFlags[3:0], 4'h7);
        // Interrupt gate: cleared on entry, status untouched, set on return
        wr(ADDR_IRQLO, 8'h05);
        chk(globalIrqGate, 1'b1);
        st = statusFlags;
        pulse(irqEntry);
        chk({globalIrqGate, irqControlLow}, {1'b0, 8'h04});
        chk(statusFlags, st);
        pulse(returnFromIrq);
        chk(globalIrqGate, 1'b1);
        wr(ADDR_IRQHI, 8'h3C);
        chk(irqControlHigh, 8'h3C);
        wr(ADDR_PADIR, 8'h0F);
        wr(ADDR_PADATA, 8'h5A);
        chk({portADirection, portAOut}, 16'h0F5A);
        rd(ADDR_PADATA);
        chk(rdv, 8'h55);
        // Both voice address sets; top two bits of the high byte drop
        for (int s = 0; s < 2; s++) begin
            vl = 8'h56 + 8'(s);
            wr(s ? ADDR_V1H : ADDR_V0H, 8'hD2);
            wr(s ? ADDR_V1M : ADDR_V0M, 8'h34);
            wr(s ? ADDR_V1L : ADDR_V0L, vl);
            chk({voiceRomReq, voiceRomAddr}, {1'b1, 6'h12, 8'h34, vl});
            w = 0;
            while (voiceRomReq === 1'b1 && w < 2000) begin
                @(negedge clk);
                w++;
            end
            chk({voiceRomReq, 1'(w == VOICE_WAIT_CYC + 1)}, 2'b01);
            @(negedge clk);
            chk(voiceRomByte, 8'h34 ^ vl);
            rd(ADDR_VBYTE);
            chk(rdv, 8'h34 ^ vl);
        end
        report_and_stop();
    end
endmodule : csr_core_regs_tb

// ---- verification/csr_far_model.sv ----
// Purpose: Far side model: program ROM, voice ROM and general RAM
// Assumes: ROM words are a fixed function of their address
// Notes:   Voice data is junk until the address has settled long enough
`timescale 1ns/10ps
module csr_far_model
    import csr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [12:0] romAddr,
    output logic      [15:0] romData,
    input  wire logic [21:0] voiceRomAddr,
    output logic      [7:0]  voiceRomData,
    input  wire logic [8:0]  memPhysAddr,
    output logic      [7:0]  ramRdata
);
    logic [21:0] lastAddr;
    logic [7:0]  lastVoice;
    int          settle;

    // Table word: high byte is the inverted low address, low byte the address
    assign romData  = {~romAddr[7:0], romAddr[7:0]};
    assign ramRdata = memPhysAddr[7:0] ^ 8'hC3;

    // A latch taken before the settle time sees changing junk, never stale data
    assign voiceRomData = (settle >= VOICE_WAIT_CYC - 8) ?
        (voiceRomAddr[15:8] ^ voiceRomAddr[7:0]) : ~lastVoice;

    // Settle counter restarts whenever the address moves
    always @(posedge clk) begin
        if (voiceRomAddr != lastAddr) begin
            settle <= 0;
        end else if (settle < 4000) begin
            settle <= settle + 1;
        end
        lastAddr  <= voiceRomAddr;
        lastVoice <= voiceRomData;
    end
endmodule : csr_far_model

// ---- verilog/csr_core_regs.sv ----
// Purpose: Special purpose registers of an 8-bit voice controller core
// Assumes: Core issues one data access per cycle with decoded events
// Notes:   ROM reads are one cycle; voice fetch waits the latch time
// Behaviour
// - Bank register 00/01 picks bank zero/one
// - Window zero always reaches bank zero
// - Reset clears bank unless sleeping watchdog reset
// - Special area visible from either bank
// - Direct addressing always uses bank zero
// - Low counter write jumps within page
// - Low counter write inserts one dummy cycle
// - Table read loads high byte, returns low
// - Watchdog divider uses low three bits
// - Status writes keep sleep and expiry flags
// - Sleep flag cleared by clear, set halt
// - Expiry flag cleared by clear/halt, set timeout
// - Carry from add, no borrow, rotate
// - Half carry from low nibble carry
// - Zero flag tracks zero result
// - Wrap flag is carry in xor out
// - Interrupt entry never saves status
// - Gate cleared on entry, set by return
// - Gate masks all sources, own enables
// - Timer count accepts direct preload writes
// - Direction one is input, zero output
// - Two 22-bit byte-built voice address registers
// - Window one follows the bank register
`timescale 1ns/10ps
module csr_core_regs (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    input  wire logic        wdtSleepReset,
    input  wire logic [7:0]  memAddr,
    input  wire logic        memWrite,
    input  wire logic        memRead,
    input  wire logic [7:0]  memWdata,
    output logic      [7:0]  memRdata,
    output logic      [8:0]  memPhysAddr,
    output logic             memPhysSel,
    input  wire logic [7:0]  ramRdata,
    input  wire logic        aluUpdate,
    input  wire logic        aluIsArith,
    input  wire logic [7:0]  aluResult,
    input  wire logic        aluCarry,
    input  wire logic        aluHalfCarry,
    input  wire logic        aluCarryIn7,
    input  wire logic        rotateCarry,
    input  wire logic        rotateCarryVal,
    input  wire logic        haltInstr,
    input  wire logic        watchdogClearInstr,
    input  wire logic        watchdogTimeout,
    input  wire logic        irqEntry,
    input  wire logic        returnFromIrq,
    input  wire logic        tableRead,
    input  wire logic [12:0] pcCurrent,
    output logic      [12:0] pcJumpAddr,
    output logic             pcJump,
    output logic             dummyCycle,
    output logic      [12:0] romAddr,
    input  wire logic [15:0] romData,
    output logic      [7:0]  tableLowByte,
    output logic             tableLowValid,
    output logic      [2:0]  watchdogDivSel,
    output logic      [7:0]  statusFlags,
    output logic             globalIrqGate,
    output logic      [7:0]  irqControlLow,
    output logic      [7:0]  irqControlHigh,
    input  wire logic [7:0]  timer0Live,
    output logic      [7:0]  timer0Preload,
    output logic             timer0Load,
    output logic      [7:0]  portADirection,
    output logic      [7:0]  portAOut,
    input  wire logic [7:0]  portAPins,
    output logic      [21:0] voiceRomAddr,
    output logic             voiceRomReq,
    input  wire logic [7:0]  voiceRomData,
    output logic      [7:0]  voiceRomByte
);
    import csr_pkg::*;

    typedef struct packed {
        logic        bank;
        logic [7:0]  ptr0;
        logic [7:0]  ptr1;
        logic [7:0]  tptr;
        logic [7:0]  thigh;
        logic [2:0]  wdsel;
        logic [7:0]  status;
        logic [7:0]  irqLo;
        logic [7:0]  irqHi;
        logic [7:0]  tmrPre;
        logic        tmrLoad;
        logic [7:0]  paDir;
        logic [7:0]  paData;
        logic [21:0] vAddr0;
        logic [21:0] vAddr1;
        logic        vSel;
        logic [21:0] vOut;
        logic        vReq;
        logic [7:0]  vByte;
        csr_vstate_e vState;
        logic [9:0]  vCnt;
        logic [7:0]  rdata;
        logic [8:0]  phys;
        logic        physSel;
        logic [12:0] jumpAddr;
        logic        jump;
        logic        dummy;
        logic [7:0]  tLow;
        logic        tLowValid;
        logic [12:0] romA;
    } csr_state_s;

    csr_state_s st_r;
    csr_state_s st_nxt;

    localparam logic [9:0] V_WAIT = 10'(VOICE_WAIT_CYC);

    // Map a logical access onto a physical 9-bit memory address
    function automatic logic [8:0] csr_phys(input logic bankBit,
                                            input logic [7:0] a);
        // Special area ignores the bank so it never hides
        if (a < SFR_TOP) begin
            csr_phys = {1'b0, a};
        end else begin
            csr_phys = {bankBit, a};
        end
    endfunction : csr_phys

    // Effective address and bank of this access
    logic [7:0] effAddr;
    logic       effBank;
    logic       isInd;
    always_comb begin
        isInd   = 1'b0;
        effAddr = memAddr;
        effBank = 1'b0;
        if (memAddr == ADDR_IND0) begin
            isInd   = 1'b1;
            effAddr = st_r.ptr0;
            effBank = 1'b0;
        end else if (memAddr == ADDR_IND1) begin
            isInd   = 1'b1;
            effAddr = st_r.ptr1;
            effBank = st_r.bank;
        end
    end

    // Next state; status is never stacked, so entry touches only the gate
    always_comb begin
        logic [7:0] wd;
        logic [7:0] rd;
        logic       wr;
        logic [7:0] a;
        wd     = memWdata;
        wr     = memWrite;
        a      = effAddr;
        rd     = ramRdata;
        st_nxt = st_r;
        st_nxt.tmrLoad   = 1'b0;
        st_nxt.jump      = 1'b0;
        st_nxt.dummy     = st_r.jump;
        st_nxt.tLowValid = 1'b0;
        st_nxt.vReq      = 1'b0;
        st_nxt.phys      = csr_phys(effBank, a);
        st_nxt.physSel   = (memRead | memWrite) & (a >= SFR_TOP);
        // Register writes, only inside the special area
        if (wr && a < SFR_TOP) begin
            unique case (a)
                ADDR_PTR0:   st_nxt.ptr0  = wd;
                ADDR_PTR1:   st_nxt.ptr1  = wd;
                ADDR_BANK:   st_nxt.bank  = wd[0];
                ADDR_PCL: begin
                    st_nxt.jumpAddr = {pcCurrent[12:8], wd};
                    st_nxt.jump     = 1'b1;
                end
                ADDR_TPTR:   st_nxt.tptr  = wd;
                ADDR_WDSEL:  st_nxt.wdsel = wd[2:0];
                ADDR_STATUS: st_nxt.status[ST_OV:ST_C] = wd[ST_OV:ST_C];
                ADDR_IRQLO:  st_nxt.irqLo = wd;
                ADDR_IRQHI:  st_nxt.irqHi = wd;
                ADDR_TIMER0_COUNT: begin
                    st_nxt.tmrPre  = wd;
                    st_nxt.tmrLoad = 1'b1;
                end
                ADDR_PADATA: st_nxt.paData = wd;
                ADDR_PADIR:  st_nxt.paDir  = wd;
                ADDR_V0H:    st_nxt.vAddr0[21:16] = wd[5:0];
                ADDR_V0M:    st_nxt.vAddr0[15:8]  = wd;
                ADDR_V1H:    st_nxt.vAddr1[21:16] = wd[5:0];
                ADDR_V1M:    st_nxt.vAddr1[15:8]  = wd;
                ADDR_V0L: begin
                    st_nxt.vAddr0[7:0] = wd;
                    st_nxt.vSel        = 1'b0;
                    st_nxt.vState      = CSR_V_WAIT;
                    st_nxt.vCnt        = V_WAIT;
                end
                ADDR_V1L: begin
                    st_nxt.vAddr1[7:0] = wd;
                    st_nxt.vSel        = 1'b1;
                    st_nxt.vState      = CSR_V_WAIT;
                    st_nxt.vCnt        = V_WAIT;
                end
                default: ;
            endcase
        end
        // Low byte write starts the fetch; full wait before the latch
        unique case (st_nxt.vState)
            CSR_V_IDLE: ;
            CSR_V_WAIT: begin
                st_nxt.vOut = st_nxt.vSel ? st_nxt.vAddr1 : st_nxt.vAddr0;
                st_nxt.vReq = 1'b1;
                if (st_r.vState == CSR_V_WAIT && st_r.vCnt <= 10'h001) begin
                    st_nxt.vState = CSR_V_LOAD;
                end else if (st_r.vState == CSR_V_WAIT) begin
                    st_nxt.vCnt = st_r.vCnt - 10'h001;
                end
            end
            CSR_V_LOAD: begin
                st_nxt.vByte  = voiceRomData;
                st_nxt.vState = CSR_V_IDLE;
            end
            default: st_nxt.vState = CSR_V_IDLE;
        endcase
        // ALU flags after any store so the latest operation wins
        if (aluUpdate) begin
            st_nxt.status[ST_Z] = (aluResult == BYTE_ZERO);
            if (aluIsArith) begin
                st_nxt.status[ST_C]  = aluCarry;
                st_nxt.status[ST_AC] = aluHalfCarry;
                st_nxt.status[ST_OV] = aluCarryIn7 ^ aluCarry;
            end
        end
        if (rotateCarry) begin
            st_nxt.status[ST_C] = rotateCarryVal;
        end
        // System flags: clear instructions first, events win last
        if (watchdogClearInstr) begin
            st_nxt.status[ST_PDF] = 1'b0;
            st_nxt.status[ST_TO]  = 1'b0;
        end
        if (haltInstr) begin
            st_nxt.status[ST_PDF] = 1'b1;
            st_nxt.status[ST_TO]  = 1'b0;
        end
        if (watchdogTimeout) begin
            st_nxt.status[ST_TO] = 1'b1;
        end
        // Gate: entry clears, return sets; entry wins if both arrive
        if (returnFromIrq) begin
            st_nxt.irqLo[IRQ_GATE_BIT] = 1'b1;
        end
        if (irqEntry) begin
            st_nxt.irqLo[IRQ_GATE_BIT] = 1'b0;
        end
        // Table read: registered ROM address, high byte kept, low handed back
        st_nxt.romA = {pcCurrent[12:8], st_nxt.tptr};
        if (tableRead) begin
            st_nxt.thigh     = romData[15:8];
            st_nxt.tLow      = romData[7:0];
            st_nxt.tLowValid = 1'b1;
        end
        // Read data; output pins report latch, inputs report pins
        unique case (a)
            ADDR_PTR0:   rd = st_r.ptr0;
            ADDR_PTR1:   rd = st_r.ptr1;
            ADDR_BANK:   rd = {7'h00, st_r.bank};
            ADDR_PCL:    rd = pcCurrent[7:0];
            ADDR_TPTR:   rd = st_r.tptr;
            ADDR_THIGH:  rd = st_r.thigh;
            ADDR_WDSEL:  rd = {5'h00, st_r.wdsel};
            ADDR_STATUS: rd = {2'h0, st_r.status[ST_TO:ST_C]};
            ADDR_IRQLO:  rd = st_r.irqLo;
            ADDR_IRQHI:  rd = st_r.irqHi;
            ADDR_TIMER0_COUNT:   rd = timer0Live;
            ADDR_PADATA: rd = (st_r.paDir & portAPins)
                            | (~st_r.paDir & st_r.paData);
            ADDR_PADIR:  rd = st_r.paDir;
            ADDR_V0H:    rd = {2'h0, st_r.vAddr0[21:16]};
            ADDR_V0M:    rd = st_r.vAddr0[15:8];
            ADDR_V0L:    rd = st_r.vAddr0[7:0];
            ADDR_V1H:    rd = {2'h0, st_r.vAddr1[21:16]};
            ADDR_V1M:    rd = st_r.vAddr1[15:8];
            ADDR_V1L:    rd = st_r.vAddr1[7:0];
            ADDR_VBYTE:  rd = st_r.vByte;
            default:     rd = (a < SFR_TOP) ? BYTE_ZERO : ramRdata;
        endcase
        if (isInd && (a == ADDR_IND0 || a == ADDR_IND1)) begin
            rd = BYTE_ZERO; // Window aimed at a window reads zero
        end
        st_nxt.rdata = memRead ? rd : st_r.rdata;
    end

    // Single register stage for all state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_r        <= '0;
            st_r.bank   <= wdtSleepReset ? st_r.bank : 1'b0;
            st_r.wdsel  <= WDSEL_RESET;
            st_r.paDir  <= PORT_RESET;
            st_r.paData <= PORT_RESET;
            st_r.status <= wdtSleepReset ? st_r.status : BYTE_ZERO;
            st_r.vState <= CSR_V_IDLE;
        end else if (clkEn) begin
            st_r <= st_nxt;
        end
    end

    assign memRdata       = st_r.rdata;
    assign memPhysAddr    = st_r.phys;
    assign memPhysSel     = st_r.physSel;
    assign pcJumpAddr     = st_r.jumpAddr;
    assign pcJump         = st_r.jump;
    assign dummyCycle     = st_r.dummy;
    assign romAddr        = st_r.romA;
    assign tableLowByte   = st_r.tLow;
    assign tableLowValid  = st_r.tLowValid;
    assign watchdogDivSel = st_r.wdsel;
    assign statusFlags    = {2'h0, st_r.status[ST_TO:ST_C]};
    assign globalIrqGate  = st_r.irqLo[IRQ_GATE_BIT];
    assign irqControlLow  = st_r.irqLo;
    assign irqControlHigh = st_r.irqHi;
    assign timer0Preload  = st_r.tmrPre;
    assign timer0Load     = st_r.tmrLoad;
    assign portADirection = st_r.paDir;
    assign portAOut       = st_r.paData;
    assign voiceRomAddr   = st_r.vOut;
    assign voiceRomReq    = st_r.vReq;
    assign voiceRomByte   = st_r.vByte;

    // Checks
    a_dummy_after_jump: assert property (@(posedge clk)
        disable iff (!reset_n) clkEn && pcJump |=> dummyCycle)
        else $error("no dummy cycle after jump");
    a_page_kept: assert property (@(posedge clk) disable iff (!reset_n)
        pcJump |-> pcJumpAddr[12:8] == $past(pcCurrent[12:8]))
        else $error("jump left page");
    a_status_sys: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && !haltInstr && !watchdogClearInstr && !watchdogTimeout
        |=> $stable(statusFlags[ST_TO:ST_PDF]))
        else $error("system flags changed");
    a_halt_sets: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && haltInstr |=> statusFlags[ST_PDF])
        else $error("halt did not set sleep flag");
    a_tmo_sets: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && watchdogTimeout |=> statusFlags[ST_TO])
        else $error("timeout flag not set");
    a_zero_flag: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && aluUpdate |=> statusFlags[ST_Z] == ($past(aluResult)
        == 8'h00))
        else $error("zero flag wrong");
    a_gate_entry: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && irqEntry |=> !globalIrqGate)
        else $error("gate not cleared on entry");
    a_ind0_bank: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && memAddr == ADDR_IND0 && memRead |=> !memPhysAddr[8])
        else $error("window zero left bank zero");
    a_voice_wait: assert property (@(posedge clk) disable iff (!reset_n)
        clkEn && st_r.vState == CSR_V_IDLE && st_nxt.vState == CSR_V_WAIT
        |=> st_r.vState != CSR_V_LOAD [*8])
        else $error("voice byte latched early");
    c_jump: cover property (@(posedge clk) pcJump ##1 dummyCycle);
    c_table: cover property (@(posedge clk) tableLowValid);
    c_voice: cover property (@(posedge clk) st_r.vState == CSR_V_LOAD);
    c_halt: cover property (@(posedge clk) haltInstr && clkEn);
endmodule : csr_core_regs

// ---- verilog/csr_pkg.sv ----
// Purpose: Constants for the core special register bank
// Assumes: Single 200 MHz clock, byte wide data memory interface
// Notes:   Offsets are data memory addresses of the special area
package csr_pkg;
    localparam int unsigned CLK_MHZ      = 200;
    localparam logic [7:0]  ADDR_IND0    = 8'h00;
    localparam logic [7:0]  ADDR_PTR0    = 8'h01;
    localparam logic [7:0]  ADDR_IND1    = 8'h02;
    localparam logic [7:0]  ADDR_PTR1    = 8'h03;
    localparam logic [7:0]  ADDR_BANK    = 8'h04;
    localparam logic [7:0]  ADDR_PCL     = 8'h06;
    localparam logic [7:0]  ADDR_TPTR    = 8'h07;
    localparam logic [7:0]  ADDR_THIGH   = 8'h08;
    localparam logic [7:0]  ADDR_WDSEL   = 8'h09;
    localparam logic [7:0]  ADDR_STATUS  = 8'h0A;
    localparam logic [7:0]  ADDR_IRQLO   = 8'h0B;
    localparam logic [7:0]  ADDR_TIMER0_COUNT    = 8'h0D;
    localparam logic [7:0]  ADDR_PADATA  = 8'h12;
    localparam logic [7:0]  ADDR_PADIR   = 8'h13;
    localparam logic [7:0]  ADDR_V0H     = 8'h18;
    localparam logic [7:0]  ADDR_V0M     = 8'h19;
    localparam logic [7:0]  ADDR_V0L     = 8'h1A;
    localparam logic [7:0]  ADDR_V1H     = 8'h1B;
    localparam logic [7:0]  ADDR_V1M     = 8'h1C;
    localparam logic [7:0]  ADDR_V1L     = 8'h1D;
    localparam logic [7:0]  ADDR_IRQHI   = 8'h1E;
    localparam logic [7:0]  ADDR_VBYTE   = 8'h2A;
    // Top of the special area; general memory starts here
    localparam logic [7:0]  SFR_TOP      = 8'h40;
    // Status bit positions
    localparam int unsigned ST_C         = 0;
    localparam int unsigned ST_AC        = 1;
    localparam int unsigned ST_Z         = 2;
    localparam int unsigned ST_OV        = 3;
    localparam int unsigned ST_PDF       = 4;
    localparam int unsigned ST_TO        = 5;
    localparam int unsigned IRQ_GATE_BIT = 0;
    localparam logic [7:0]  PORT_RESET   = 8'hFF;
    localparam logic [7:0]  BYTE_ZERO    = 8'h00;
    localparam logic [2:0]  WDSEL_RESET  = 3'h7;
    localparam int unsigned VOICE_WAIT_NS = 4000;
    localparam int unsigned VOICE_WAIT_CYC =
        (VOICE_WAIT_NS * CLK_MHZ + 999) / 1000;
    // Voice latch wait state machine
    typedef enum logic [1:0] {
        CSR_V_IDLE = 2'b00,
        CSR_V_WAIT = 2'b01,
        CSR_V_LOAD = 2'b11
    } csr_vstate_e;
endpackage : csr_pkg
